// file: design/msf_status_unit.v
// motion status flag unit: status flags, error latches and forced stop handling
`timescale 1ns/1ns
`default_nettype none
`include "msf_map.vh"
module msf_status_unit #(
  parameter MAIN_DIV = `MSF_MAIN_CYCLE_NS / `MSF_CLK_NS,
  parameter DW = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irq_o,
  input wire wdt_error_i,
  input wire [DW-1:0] wdt_cause_i,
  input wire check_done_i,
  input wire check_ok_i,
  output reg check_start_o,
  output reg servo_param_write_o,
  output reg mcode_clear_o,
  input wire test_mode_i,
  input wire test_req_i,
  input wire test_req_fail_i,
  input wire [2*DW-1:0] test_err_info_i,
  input wire handwheel_err_i,
  input wire [3*DW-1:0] handwheel_err_info_i,
  input wire sprog_invalid_i,
  input wire forced_stop_pin_i,
  input wire positioning_i,
  input wire [31:0] feed_cmd_i,
  output reg [31:0] feed_value_o,
  output reg axes_stop_o,
  output reg all_axes_servo_on_command_o
);
  // ----------------------------------------
  // synchronisers for pin inputs
  // ----------------------------------------
  reg fstop_s1_r, fstop_s2_r, wdt_s1_r, wdt_s2_r;
  // two flops per asynchronous input
  always @(posedge clk_i) begin
    if (rst_i) begin
      fstop_s1_r <= 1'b0;
      fstop_s2_r <= 1'b0;
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
    end else begin
      fstop_s1_r <= forced_stop_pin_i;
      fstop_s2_r <= fstop_s1_r;
      wdt_s1_r <= wdt_error_i;
      wdt_s2_r <= wdt_s1_r;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  reg ack_r;
  reg [31:0] ctrl_r, stop_time_r;
  reg [7:0] irq_stat_r, irq_mask_r, flags_r;
  wire acc = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = acc & wb_we_i;
  wire wr_ctrl = wr & (wb_adr_i == `MSF_ADR_CTRL) & wb_sel_i[0];
  wire clr_wdt = wr_ctrl & wb_dat_i[`MSF_CTRL_CLR_WDT];
  wire clr_trq = wr_ctrl & wb_dat_i[`MSF_CTRL_CLR_TRQ];
  wire clr_hw = wr_ctrl & wb_dat_i[`MSF_CTRL_CLR_HW];
  wire clr_servo = wr_ctrl & wb_dat_i[`MSF_CTRL_CLR_SERVO];
  wire host_ready_command = ctrl_r[`MSF_CTRL_READY_CMD];
  assign wb_ack_o = ack_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ack one cycle after request, writes of control, mask, stop time
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      ctrl_r <= 32'h00000000;
      irq_mask_r <= 8'h00;
      stop_time_r <= `MSF_RST_STOP_TIME;
    end else begin
      ack_r <= acc;
      if (wr_ctrl)
        ctrl_r <= {31'h00000000, wb_dat_i[`MSF_CTRL_READY_CMD]}; // clear bits self-clear
      if (wr & (wb_adr_i == `MSF_ADR_IRQ_MASK) & wb_sel_i[0])
        irq_mask_r <= wb_dat_i[7:0];
      if (wr & (wb_adr_i == `MSF_ADR_STOP_TIME))
        stop_time_r <= wb_dat_i;
    end
  end

  // ----------------------------------------
  // main cycle divider
  // ----------------------------------------
  reg [31:0] div_r;
  wire main_tick = (div_r == MAIN_DIV - 1);
  always @(posedge clk_i) begin
    if (rst_i)
      div_r <= 32'h00000000;
    else
      div_r <= main_tick ? 32'h00000000 : div_r + 32'h00000001;
  end

  // ----------------------------------------
  // error flags and latched information
  // ----------------------------------------
  reg wdt_flag_r, trq_flag_r, hw_flag_r, servo_err_r;
  reg [DW-1:0] wdt_cause_r;
  reg [2*DW-1:0] trq_info_r;
  reg [3*DW-1:0] hw_info_r;
  wire trq_event = test_req_i & (test_mode_i | test_req_fail_i);
  wire servo_err_event;
  // set wins over clear; info latched only on the setting edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      wdt_flag_r <= 1'b0;
      trq_flag_r <= 1'b0;
      hw_flag_r <= 1'b0;
      servo_err_r <= 1'b0;
      wdt_cause_r <= {DW{1'b0}};
      trq_info_r <= {2*DW{1'b0}};
      hw_info_r <= {3*DW{1'b0}};
    end else begin
      if (wdt_s2_r)
        wdt_flag_r <= 1'b1;
      else if (clr_wdt)
        wdt_flag_r <= 1'b0;
      if (wdt_s2_r & ~wdt_flag_r)
        wdt_cause_r <= wdt_cause_i;
      if (trq_event)
        trq_flag_r <= 1'b1;
      else if (clr_trq)
        trq_flag_r <= 1'b0;
      if (trq_event & ~trq_flag_r)
        trq_info_r <= test_err_info_i;
      if (handwheel_err_i)
        hw_flag_r <= 1'b1;
      else if (clr_hw)
        hw_flag_r <= 1'b0;
      if (handwheel_err_i & ~hw_flag_r)
        hw_info_r <= handwheel_err_info_i;
      if (servo_err_event)
        servo_err_r <= 1'b1;
      else if (clr_servo)
        servo_err_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // ready sequence
  // ----------------------------------------
  localparam RS_IDLE = 2'd0;
  localparam RS_CHECK = 2'd1;
  localparam RS_READY = 2'd2;
  reg [1:0] rs_r;
  reg ready_cmd_d_r, ready_r;
  // off-to-on of ready command starts checks
  always @(posedge clk_i) begin
    if (rst_i) begin
      rs_r <= RS_IDLE;
      ready_cmd_d_r <= 1'b0;
      ready_r <= 1'b0;
      check_start_o <= 1'b0;
      servo_param_write_o <= 1'b0;
      mcode_clear_o <= 1'b0;
    end else begin
      ready_cmd_d_r <= host_ready_command;
      check_start_o <= 1'b0;
      servo_param_write_o <= 1'b0;
      mcode_clear_o <= 1'b0;
      if (!host_ready_command) begin
        rs_r <= RS_IDLE;
        ready_r <= 1'b0;
      end else begin
        case (rs_r)
          RS_IDLE: begin
            if (!ready_cmd_d_r) begin
              rs_r <= RS_CHECK;
              check_start_o <= 1'b1;
            end
          end
          RS_CHECK: begin
            if (check_done_i) begin
              if (check_ok_i) begin
                rs_r <= RS_READY;
                ready_r <= 1'b1;
                servo_param_write_o <= 1'b1;
                mcode_clear_o <= 1'b1;
              end else begin
                rs_r <= RS_READY; // wait for command off
              end
            end
          end
          RS_READY: rs_r <= RS_READY;
          default: rs_r <= RS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // forced stop handling
  // ----------------------------------------
  localparam FS_RUN = 2'd0;
  localparam FS_DECEL = 2'd1;
  localparam FS_HELD = 2'd2;
  reg [1:0] fs_r;
  reg [31:0] fs_cnt_r, feed_cap_r;
  assign servo_err_event = (fs_r == FS_DECEL) & ~fstop_s2_r;
  // feed advances during decel, restored after stop time
  always @(posedge clk_i) begin
    if (rst_i) begin
      fs_r <= FS_RUN;
      fs_cnt_r <= 32'h00000000;
      feed_cap_r <= 32'h00000000;
      feed_value_o <= 32'h00000000;
      axes_stop_o <= 1'b0;
      all_axes_servo_on_command_o <= 1'b0;
    end else begin
      axes_stop_o <= wdt_flag_r | wdt_s2_r;
      case (fs_r)
        FS_RUN: begin
          all_axes_servo_on_command_o <= 1'b1;
          if (!wdt_s2_r)
            feed_value_o <= feed_cmd_i; // immediate stop freezes feed
          if (fstop_s2_r & positioning_i) begin
            fs_r <= FS_DECEL;
            feed_cap_r <= feed_value_o;
            fs_cnt_r <= 32'h00000000;
            all_axes_servo_on_command_o <= 1'b0;
          end
        end
        FS_DECEL: begin
          all_axes_servo_on_command_o <= 1'b0;
          feed_value_o <= feed_cmd_i;
          fs_cnt_r <= fs_cnt_r + 32'h00000001;
          if (!fstop_s2_r)
            fs_r <= FS_RUN;
          else if (fs_cnt_r >= stop_time_r) begin
            feed_value_o <= feed_cap_r;
            fs_r <= FS_HELD;
          end
        end
        FS_HELD: begin
          all_axes_servo_on_command_o <= 1'b0;
          if (!fstop_s2_r)
            fs_r <= FS_RUN;
        end
        default: fs_r <= FS_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // flag refresh once per main cycle, irq status every clock
  // ----------------------------------------
  wire [7:0] flags_live;
  assign flags_live[`MSF_BIT_WDT] = wdt_flag_r;
  assign flags_live[`MSF_BIT_READY] = ready_r;
  assign flags_live[`MSF_BIT_TEST_ON] = test_mode_i;
  assign flags_live[`MSF_BIT_FSTOP] = fstop_s2_r;
  assign flags_live[`MSF_BIT_HW_ERR] = hw_flag_r;
  assign flags_live[`MSF_BIT_TRQ_ERR] = trq_flag_r;
  assign flags_live[`MSF_BIT_SPROG_ERR] = sprog_invalid_i;
  assign flags_live[`MSF_BIT_SERVO_ERR] = servo_err_r;
  wire [7:0] ev_set = {servo_err_event, 1'b0, trq_event, handwheel_err_i, 1'b0,
    1'b0, 1'b0, wdt_s2_r};
  wire wr_stat = wr & (wb_adr_i == `MSF_ADR_IRQ_STAT) & wb_sel_i[0];
  // snapshot on tick, sticky irq status with write-one-to-clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= 8'h00;
      irq_stat_r <= 8'h00;
    end else begin
      if (main_tick)
        flags_r <= flags_live;
      irq_stat_r <= ev_set | (irq_stat_r & ~(wr_stat ? wb_dat_i[7:0] : 8'h00));
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (acc & ~wb_we_i) begin
      case (wb_adr_i)
        `MSF_ADR_FLAGS: wb_dat_o <= {24'h000000, flags_r};
        `MSF_ADR_IRQ_STAT: wb_dat_o <= {24'h000000, irq_stat_r};
        `MSF_ADR_IRQ_MASK: wb_dat_o <= {24'h000000, irq_mask_r};
        `MSF_ADR_WDT_CAUSE: wb_dat_o <= {{(32-DW){1'b0}}, wdt_cause_r};
        `MSF_ADR_TRQ_INFO0: wb_dat_o <= {{(32-DW){1'b0}}, trq_info_r[DW-1:0]};
        `MSF_ADR_TRQ_INFO1: wb_dat_o <= {{(32-DW){1'b0}}, trq_info_r[2*DW-1:DW]};
        `MSF_ADR_HW_INFO0: wb_dat_o <= {{(32-DW){1'b0}}, hw_info_r[DW-1:0]};
        `MSF_ADR_HW_INFO1: wb_dat_o <= {{(32-DW){1'b0}}, hw_info_r[2*DW-1:DW]};
        `MSF_ADR_HW_INFO2: wb_dat_o <= {{(32-DW){1'b0}}, hw_info_r[3*DW-1:2*DW]};
        `MSF_ADR_CTRL: wb_dat_o <= ctrl_r;
        `MSF_ADR_STOP_TIME: wb_dat_o <= stop_time_r;
        `MSF_ADR_FEED: wb_dat_o <= feed_value_o;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: include/msf_map.vh
// register offsets, field positions and reset values of the motion status flag unit
`ifndef MSF_MAP_VH
`define MSF_MAP_VH
`define MSF_ADR_FLAGS 6'h00
`define MSF_ADR_IRQ_STAT 6'h04
`define MSF_ADR_IRQ_MASK 6'h08
`define MSF_ADR_WDT_CAUSE 6'h0c
`define MSF_ADR_TRQ_INFO0 6'h10
`define MSF_ADR_TRQ_INFO1 6'h14
`define MSF_ADR_HW_INFO0 6'h18
`define MSF_ADR_HW_INFO1 6'h1c
`define MSF_ADR_HW_INFO2 6'h20
`define MSF_ADR_CTRL 6'h24
`define MSF_ADR_STOP_TIME 6'h28
`define MSF_ADR_FEED 6'h2c
`define MSF_BIT_WDT 0
`define MSF_BIT_READY 1
`define MSF_BIT_TEST_ON 2
`define MSF_BIT_FSTOP 3
`define MSF_BIT_HW_ERR 4
`define MSF_BIT_TRQ_ERR 5
`define MSF_BIT_SPROG_ERR 6
`define MSF_BIT_SERVO_ERR 7
`define MSF_CTRL_READY_CMD 0
`define MSF_CTRL_CLR_WDT 1
`define MSF_CTRL_CLR_TRQ 2
`define MSF_CTRL_CLR_HW 3
`define MSF_CTRL_CLR_SERVO 4
`define MSF_RST_STOP_TIME 32'h000003e8
`define MSF_MAIN_CYCLE_NS 3500000
`define MSF_CLK_NS 20
`endif

// file: testbench/msf_status_monitor.sv
// port checker for the motion status flag unit
`timescale 1ns/1ns
`default_nettype none
module msf_status_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic check_start_o,
  input wire logic check_done_i,
  input wire logic check_ok_i,
  input wire logic servo_param_write_o,
  input wire logic mcode_clear_o,
  input wire logic wdt_error_i,
  input wire logic axes_stop_o,
  input wire logic forced_stop_pin_i,
  input wire logic positioning_i,
  input wire logic all_axes_servo_on_command_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer timing
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // ready handshake
  a_start_single: assert property (check_start_o |=> !check_start_o)
    else $error("start not a pulse");
  a_param_on_ok: assert property (
    servo_param_write_o |-> $past(check_done_i && check_ok_i))
    else $error("param write without clean check");
  a_param_mcode_pair: assert property (servo_param_write_o == mcode_clear_o)
    else $error("param and mcode pulses apart");
  // stop handling and quiet outputs after reset
  a_wdt_stops_axes: assert property (wdt_error_i [*4] |-> ##[0:4] axes_stop_o)
    else $error("axes not stopped");
  a_fstop_servo_off: assert property ((forced_stop_pin_i && positioning_i) [*8] |->
    !all_axes_servo_on_command_o) else $error("servo on during forced stop");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !all_axes_servo_on_command_o)
    else $error("outputs active after reset");
endmodule
bind msf_status_unit msf_status_monitor i_msf_status_monitor (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .irq_o, .check_start_o, .check_done_i, .check_ok_i,
  .servo_param_write_o, .mcode_clear_o, .wdt_error_i, .axes_stop_o, .forced_stop_pin_i,
  .positioning_i, .all_axes_servo_on_command_o);
`default_nettype wire

// file: testbench/msf_check_model.sv
// parameter check engine answering the ready checks
`timescale 1ns/1ns
`default_nettype none
module msf_check_model #(parameter int DLY = 3) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic ok_sel_i,
  output logic done_o,
  output logic ok_o
);
  int cnt;
  // one done pulse per start; ok shows garbage outside done
  always @(posedge clk_i) begin
    cnt <= rst_i ? 0 : start_i ? DLY : (cnt > 0) ? cnt - 1 : 0;
    done_o <= !rst_i && cnt == 1;
    ok_o <= (cnt == 1) ? ok_sel_i : ~ok_o;
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the motion status flag unit
`timescale 1ns/1ns
`default_nettype none
`include "msf_map.vh"
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, wdt = 0, okc = 0, tmode = 0, treq = 0;
  logic tfail = 0, herr = 0, sprog = 0, fpin = 0, pos = 0, cdone, cok, cstart, spw, mcc;
  logic ack, irq, astop, son;
  logic [5:0] adr = 0;
  logic [15:0] wcause = 0;
  logic [31:0] wdat = 0, tinfo = 0, feed = 0, rdat, fval;
  logic [47:0] hinfo = 0;
  int err_total = 0, n_compared = 0;
  always #10 clk_i = ~clk_i;
  msf_status_unit #(.MAIN_DIV(8)) i_msf_status_unit (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wdt_error_i(wdt), .wdt_cause_i(wcause),
    .check_done_i(cdone), .check_ok_i(cok), .check_start_o(cstart),
    .servo_param_write_o(spw), .mcode_clear_o(mcc), .test_mode_i(tmode), .test_req_i(treq),
    .test_req_fail_i(tfail), .test_err_info_i(tinfo), .handwheel_err_i(herr),
    .handwheel_err_info_i(hinfo), .sprog_invalid_i(sprog), .forced_stop_pin_i(fpin),
    .positioning_i(pos), .feed_cmd_i(feed), .feed_value_o(fval), .axes_stop_o(astop),
    .all_axes_servo_on_command_o(son));
  msf_check_model i_msf_check_model (.clk_i, .rst_i, .start_i(cstart), .ok_sel_i(okc),
    .done_o(cdone), .ok_o(cok));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; stop_test(); end
    q = rdat;
    cyc <= 0; we <= 0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 0, q);
    chk(q, e);
  endtask
  task automatic tick;
    repeat (24) @(posedge clk_i);
  endtask
  task automatic reset;
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
  endtask
  task automatic pulses(input logic [31:0] e);
    int p = 0, m = 0;
    repeat (30) begin
      @(posedge clk_i);
      p += (spw !== 1'b0);
      m += (mcc !== 1'b0);
    end
    chk(p, e); chk(m, e);
  endtask
  task automatic t_init;
    rd(`MSF_ADR_STOP_TIME, `MSF_RST_STOP_TIME);
    rd(`MSF_ADR_FLAGS, 0);
    wr(6'h3c, 32'hffff_ffff);
    rd(6'h3c, 0);
    $display("test init done");
  endtask
  task automatic t_ready;
    wr(`MSF_ADR_CTRL, 1);
    pulses(0);
    tick; rd(`MSF_ADR_FLAGS, 0);
    wr(`MSF_ADR_CTRL, 0); okc <= 1;
    wr(`MSF_ADR_CTRL, 1);
    pulses(1);
    tick; rd(`MSF_ADR_FLAGS, 32'h2);
    wr(`MSF_ADR_CTRL, 0);
    tick; rd(`MSF_ADR_FLAGS, 0);
    $display("test ready done");
  endtask
  task automatic t_wdt;
    chk(32'(astop), 0);
    wcause <= 16'h1234;
    wdt <= 1;
    tick; chk(32'(astop), 1);
    rd(`MSF_ADR_FLAGS, 32'h1);
    rd(`MSF_ADR_WDT_CAUSE, 32'h1234);
    wcause <= 16'h5678; wdt <= 0;
    tick; rd(`MSF_ADR_WDT_CAUSE, 32'h1234);
    rd(`MSF_ADR_IRQ_STAT, 32'h1);
    chk(32'(irq), 0);
    wr(`MSF_ADR_IRQ_MASK, 1);
    @(posedge clk_i); chk(32'(irq), 1);
    wr(`MSF_ADR_IRQ_STAT, 1);
    @(posedge clk_i); chk(32'(irq), 0);
    wr(`MSF_ADR_CTRL, 32'h2);
    tick; rd(`MSF_ADR_FLAGS, 0);
    wdt <= 1; tick; wdt <= 0;
    reset; tick; rd(`MSF_ADR_FLAGS, 0);
    $display("test watchdog done");
  endtask
  task automatic t_test;
    tmode <= 1; tinfo <= 32'hcafe_0001; treq <= 1;
    @(posedge clk_i) treq <= 0;
    tick; rd(`MSF_ADR_FLAGS, 32'h24);
    rd(`MSF_ADR_TRQ_INFO0, 32'h0001);
    rd(`MSF_ADR_TRQ_INFO1, 32'hcafe);
    wr(`MSF_ADR_CTRL, 32'h4); tmode <= 0;
    tick; rd(`MSF_ADR_FLAGS, 0);
    treq <= 1; tfail <= 1;
    @(posedge clk_i) treq <= 0;
    tick; rd(`MSF_ADR_FLAGS, 32'h20);
    wr(`MSF_ADR_CTRL, 32'h4);
    $display("test request done");
  endtask
  task automatic t_misc;
    hinfo <= 48'h3333_2222_1111; herr <= 1;
    @(posedge clk_i) herr <= 0;
    tick; rd(`MSF_ADR_FLAGS, 32'h10);
    for (int i = 0; i < 3; i++) begin
      rd(6'(`MSF_ADR_HW_INFO0 + 4 * i), {16'h0, hinfo[16 * i +: 16]});
    end
    wr(`MSF_ADR_CTRL, 32'h8); sprog <= 1;
    tick; rd(`MSF_ADR_FLAGS, 32'h40);
    sprog <= 0;
    tick; rd(`MSF_ADR_FLAGS, 0);
    $display("test handwheel done");
  endtask
  task automatic t_fstop;
    chk(32'(son), 1);
    feed <= 32'h100; pos <= 1;
    wr(`MSF_ADR_STOP_TIME, 20);
    repeat (5) @(posedge clk_i);
    fpin <= 1;
    repeat (10) @(posedge clk_i);
    chk(32'(son), 0);
    feed <= 32'h200;
    repeat (3) @(posedge clk_i);
    chk(fval, 32'h200);
    repeat (40) @(posedge clk_i);
    chk(fval, 32'h100);
    rd(`MSF_ADR_FEED, 32'h100);
    rd(`MSF_ADR_FLAGS, 32'h8);
    fpin <= 0;
    tick; rd(`MSF_ADR_FLAGS, 0);
    fpin <= 1;
    repeat (12) @(posedge clk_i);
    fpin <= 0;
    tick; rd(`MSF_ADR_FLAGS, 32'h80);
    wr(`MSF_ADR_CTRL, 32'h10);
    tick; rd(`MSF_ADR_FLAGS, 0);
    $display("test forced stop done");
  endtask
  initial begin
    reset;
    t_init;
    t_ready;
    t_wdt;
    t_test;
    t_misc;
    t_fstop;
    stop_test();
  end
endmodule
`default_nettype wire
